// ### verilog/ulsm_pkg.sv
// Package for the link-side ULPI serial/UART mode controller.
// Assumes a ULPI transceiver whose register map follows the ULPI set/clear layout.
package ulsm_pkg;

  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_DATA, ST_STP, ST_WAITDIR, ST_PRE,
    ST_SER, ST_UART, ST_EXIT, ST_CS_OFF, ST_CS_WAIT
  } ulsm_state_e;

  // User orders
  typedef enum logic [1:0] {
    CMD_ENTER_SERIAL, CMD_ENTER_UART, CMD_EXIT_STOP, CMD_EXIT_CS
  } ulsm_cmd_e;

  // One register write of an entry sequence
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
    logic last;
  } ulsm_step_s;

  // Register write opcode in the transmit command byte
  localparam logic [1:0] TXCMD_REGWR = 2'h2;

  // Set and clear addresses of the transceiver registers
  localparam logic [5:0] FUNC_SET = 6'h05;
  localparam logic [5:0] FUNC_CLR = 6'h06;
  localparam logic [5:0] IFC_SET = 6'h08;
  localparam logic [5:0] OTG_CLR = 6'h0C;
  localparam logic [5:0] CARKIT_SET = 6'h1A;

  // Field masks
  localparam logic [7:0] FUNC_SPEED_TERM = 8'h07; // transceiver_speed_sel and termination_sel
  localparam logic [7:0] SPEED_LOW = 8'h02;
  localparam logic [7:0] SPEED_FULL = 8'h01;
  localparam logic [7:0] OTG_PULLDOWNS = 8'h06; // plus/minus_line_pulldown_en
  localparam logic [7:0] IFC_THREE_WIRE = 8'h02; // three_wire_serial_en
  localparam logic [7:0] IFC_CARKIT = 8'h04;
  localparam logic [7:0] IFC_CLK_KEEP = 8'h08; // clock_keep_alive
  localparam logic [7:0] CARKIT_UART_EN = 8'h0C; // transmit and receive enables

  // Timing
  localparam int CLK_NS = 20;
  localparam logic [2:0] SER_TURN_CYC = 3'h1;
  localparam logic [2:0] UART_PRE_CYC = 3'h6; // turnaround plus five precharge cycles
  localparam logic [2:0] SER_LAST_IDX = 3'h1;
  localparam logic [2:0] UART_LAST_IDX = 3'h5;

endpackage : ulsm_pkg

// ### verilog/ulsm_ctrl.sv
// Link-side controller that moves a ULPI transceiver into 3-pin serial or UART mode and back.
// Assumes clk is the ULPI clock domain and all ULPI pins are synchronous to it.
// Notes on behaviour
// - Enter 3-pin serial by writing three_wire_serial_en to 1.
// - Leave 3-pin serial by raising stop; bus returns to synchronous mode.
// - Write clock_keep_alive to 1 before entry when the clock must keep running.
// - Serial mode: data bit 0 is our transmit enable.
// - Serial mode: bit 1 carries transmit data when enabled, receive data otherwise.
// - Serial mode: bit 2 carries SE0 request when enabled, received SE0 otherwise.
// - Before UART entry select low-speed or full-speed transceiver.
// - During UART setup clear both line pull-downs.
// - During UART setup clear termination_sel.
// - Set UART transmit and receive enables together in one write.
// - Device precharges bit 0 five cycles after turnaround; link may drive after.
// - Clock stops in UART mode unless clock_keep_alive was set first.
// - UART mode ends by stop high or chip-select toggle.
// - Interrupt seen in UART mode: raise stop, then read the latch register.
// - Stop held high wakes the device back to synchronous mode.
`timescale 1ns/1ps

module ulsm_ctrl #(
  parameter int POWERDOWN_HOLD_NS = 1000
) (
  input wire logic clk, // ULPI clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic cmd_valid, // Order present
  input wire ulsm_pkg::ulsm_cmd_e cmd, // Order code
  output logic cmd_ready, // Order accepted this cycle
  input wire logic keep_clock, // Keep clock running in the alternate mode
  input wire logic uart_low_speed, // Low-speed driver for UART, else full-speed
  input wire logic ser_tx_en, // Serial transmit enable
  input wire logic ser_tx_dat, // Serial transmit differential data
  input wire logic ser_tx_se0, // Serial transmit SE0 request
  output logic ser_rx_dat, // Serial received differential data
  output logic ser_rx_se0, // Serial received SE0
  input wire logic uart_txd, // UART transmit toward the minus line
  output logic uart_rxd, // UART receive from the plus line
  output logic mode_serial, // In 3-pin serial mode
  output logic mode_uart, // In UART mode
  output logic int_seen, // Interrupt woke the device; read latch register
  output logic busy, // Sequence in progress
  input wire logic ulpi_dir, // ULPI direction
  input wire logic ulpi_nxt, // ULPI next
  output logic ulpi_stp, // ULPI stop
  input wire logic [7:0] ulpi_data_in, // ULPI data pin level
  output logic [7:0] ulpi_data_out, // ULPI data drive value
  output logic [7:0] ulpi_data_oe, // ULPI data per-bit drive enable
  output logic phy_cs // Transceiver chip select, active high
);

  localparam int CS_CYC_I = (POWERDOWN_HOLD_NS + ulsm_pkg::CLK_NS - 1) / ulsm_pkg::CLK_NS + 1;
  localparam logic [15:0] CS_CYC = 16'(CS_CYC_I);

  ulsm_pkg::ulsm_state_e state_reg, state_next;
  logic uart_sel_reg;
  logic [2:0] idx_reg;
  logic [2:0] cnt_reg;
  logic [15:0] cs_cnt_reg;
  logic stp_reg, cs_reg, int_reg;
  logic [7:0] dout_reg, dout_next, oe_reg, oe_next;
  logic in_mode;
  ulsm_pkg::ulsm_step_s step;
  logic uart_sel_next;
  logic [2:0] idx_next;
  ulsm_pkg::ulsm_step_s step_nx;
  logic [15:0] cs_low_cnt_reg;

  // Entry sequences; a clear clock_keep_alive becomes a harmless zero set write
  function automatic ulsm_pkg::ulsm_step_s step_of(input logic uart, input logic [2:0] idx,
                                                   input logic keep, input logic low);
    ulsm_pkg::ulsm_step_s s;
    logic [7:0] keep_bits;
    keep_bits = keep ? ulsm_pkg::IFC_CLK_KEEP : 8'h00;
    s = '{addr: ulsm_pkg::IFC_SET, data: keep_bits, last: 1'b0};
    if (!uart) begin
      if (idx == ulsm_pkg::SER_LAST_IDX) begin
        s = '{addr: ulsm_pkg::IFC_SET, data: ulsm_pkg::IFC_THREE_WIRE, last: 1'b1};
      end
    end else if (idx == 3'h0) begin
      s = '{addr: ulsm_pkg::FUNC_CLR, data: ulsm_pkg::FUNC_SPEED_TERM, last: 1'b0};
    end else if (idx == 3'h1) begin
      s.addr = ulsm_pkg::FUNC_SET;
      s.data = low ? ulsm_pkg::SPEED_LOW : ulsm_pkg::SPEED_FULL;
    end else if (idx == 3'h2) begin
      s = '{addr: ulsm_pkg::OTG_CLR, data: ulsm_pkg::OTG_PULLDOWNS, last: 1'b0};
    end else if (idx == 3'h4) begin
      s = '{addr: ulsm_pkg::CARKIT_SET, data: ulsm_pkg::CARKIT_UART_EN, last: 1'b0};
    end else if (idx == ulsm_pkg::UART_LAST_IDX) begin
      s = '{addr: ulsm_pkg::IFC_SET, data: ulsm_pkg::IFC_CARKIT, last: 1'b1};
    end
    return s;
  endfunction : step_of

  assign step = step_of(uart_sel_reg, idx_reg, keep_clock, uart_low_speed);

  // Selection and index of the coming cycle; the bus byte is registered one cycle ahead,
  // so it must follow these or a TXCMD would carry the previous step's address
  always_comb begin
    uart_sel_next = uart_sel_reg;
    idx_next = idx_reg;
    if (state_reg == ulsm_pkg::ST_IDLE && cmd_valid && cmd_ready) begin
      uart_sel_next = (cmd == ulsm_pkg::CMD_ENTER_UART);
      idx_next = 3'h0;
    end else if (state_reg == ulsm_pkg::ST_STP && !step.last) begin
      idx_next = idx_reg + 3'h1;
    end
  end

  assign step_nx = step_of(uart_sel_next, idx_next, keep_clock, uart_low_speed);
  assign in_mode = (state_reg == ulsm_pkg::ST_SER) || (state_reg == ulsm_pkg::ST_UART);

  // Enter orders only when idle, exit orders only while in a mode
  always_comb begin
    cmd_ready = 1'b0;
    if (state_reg == ulsm_pkg::ST_IDLE) begin
      cmd_ready = (cmd == ulsm_pkg::CMD_ENTER_SERIAL) || (cmd == ulsm_pkg::CMD_ENTER_UART);
    end else if (in_mode) begin
      cmd_ready = (cmd == ulsm_pkg::CMD_EXIT_STOP) || (cmd == ulsm_pkg::CMD_EXIT_CS);
    end
  end

  // Sequencer; nxt only counts while dir is low, so it is ignored inside the modes
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ulsm_pkg::ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          state_next = ulsm_pkg::ST_CMD;
        end
      end
      ulsm_pkg::ST_CMD: begin
        if (ulpi_nxt && !ulpi_dir) begin
          state_next = ulsm_pkg::ST_DATA;
        end
      end
      ulsm_pkg::ST_DATA: begin
        if (ulpi_dir) begin
          state_next = ulsm_pkg::ST_CMD; // Write lost to a receive command; retry it
        end else if (ulpi_nxt) begin
          state_next = ulsm_pkg::ST_STP;
        end
      end
      ulsm_pkg::ST_STP: begin
        state_next = step.last ? ulsm_pkg::ST_WAITDIR : ulsm_pkg::ST_CMD;
      end
      ulsm_pkg::ST_WAITDIR: begin
        if (ulpi_dir) begin
          state_next = ulsm_pkg::ST_PRE;
        end
      end
      ulsm_pkg::ST_PRE: begin
        if (cnt_reg == 3'h1) begin
          state_next = uart_sel_reg ? ulsm_pkg::ST_UART : ulsm_pkg::ST_SER;
        end
      end
      ulsm_pkg::ST_SER, ulsm_pkg::ST_UART: begin
        if (ulpi_data_in[3]) begin
          state_next = ulsm_pkg::ST_EXIT;
        end else if (cmd_valid && cmd_ready) begin
          state_next = (cmd == ulsm_pkg::CMD_EXIT_CS) ? ulsm_pkg::ST_CS_OFF
                                                      : ulsm_pkg::ST_EXIT;
        end
      end
      ulsm_pkg::ST_EXIT: begin
        if (!ulpi_dir) begin
          state_next = ulsm_pkg::ST_IDLE;
        end
      end
      ulsm_pkg::ST_CS_OFF: begin
        if (cs_cnt_reg == 16'h0001) begin
          state_next = ulsm_pkg::ST_CS_WAIT;
        end
      end
      ulsm_pkg::ST_CS_WAIT: begin
        if (!ulpi_dir) begin
          state_next = ulsm_pkg::ST_IDLE;
        end
      end
      default: state_next = ulsm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= ulsm_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Sequence selection and step index
  always_ff @(posedge clk) begin
    if (!rstn) begin
      uart_sel_reg <= 1'b0;
      idx_reg <= 3'h0;
    end else begin
      uart_sel_reg <= uart_sel_next;
      idx_reg <= idx_next;
    end
  end

  // Turnaround and precharge window, chip-select off time
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_reg <= 3'h0;
      cs_cnt_reg <= 16'h0000;
    end else begin
      if (state_reg == ulsm_pkg::ST_WAITDIR) begin
        cnt_reg <= uart_sel_reg ? ulsm_pkg::UART_PRE_CYC : ulsm_pkg::SER_TURN_CYC;
      end else if (cnt_reg != 3'h0) begin
        cnt_reg <= cnt_reg - 3'h1;
      end
      if (state_next == ulsm_pkg::ST_CS_OFF && state_reg != ulsm_pkg::ST_CS_OFF) begin
        cs_cnt_reg <= CS_CYC;
      end else if (cs_cnt_reg != 16'h0000) begin
        cs_cnt_reg <= cs_cnt_reg - 16'h0001;
      end
    end
  end

  // Stop, chip select and the interrupt flag; a new entry clears the flag
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stp_reg <= 1'b0;
      cs_reg <= 1'b1;
      int_reg <= 1'b0;
    end else begin
      stp_reg <= (state_next == ulsm_pkg::ST_STP) || (state_next == ulsm_pkg::ST_EXIT);
      cs_reg <= (state_next != ulsm_pkg::ST_CS_OFF);
      if (in_mode && ulpi_data_in[3]) begin
        int_reg <= 1'b1;
      end else if (state_reg == ulsm_pkg::ST_IDLE && cmd_valid && cmd_ready) begin
        int_reg <= 1'b0;
      end
    end
  end

  // Data drive for the coming state; bits 7..3 are never driven inside the modes
  always_comb begin
    dout_next = 8'h00;
    oe_next = 8'h00;
    case (state_next)
      ulsm_pkg::ST_CMD: begin
        dout_next = {ulsm_pkg::TXCMD_REGWR, step_nx.addr};
        oe_next = 8'hFF;
      end
      ulsm_pkg::ST_DATA: begin
        dout_next = step_nx.data;
        oe_next = 8'hFF;
      end
      ulsm_pkg::ST_STP: begin
        oe_next = 8'hFF;
      end
      ulsm_pkg::ST_SER: begin
        dout_next = {5'h00, ser_tx_se0, ser_tx_dat, ser_tx_en};
        oe_next = {5'h00, ser_tx_en, ser_tx_en, 1'b1};
      end
      ulsm_pkg::ST_UART: begin
        dout_next = {7'h00, uart_txd};
        oe_next = 8'h01;
      end
      default: begin
        dout_next = 8'h00;
        oe_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dout_reg <= 8'h00;
      oe_reg <= 8'h00;
    end else begin
      dout_reg <= dout_next;
      oe_reg <= oe_next;
    end
  end

  // Receive side of the modes, sampled into flip-flops
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ser_rx_dat <= 1'b0;
      ser_rx_se0 <= 1'b0;
      uart_rxd <= 1'b1;
    end else begin
      if (state_reg == ulsm_pkg::ST_SER && !oe_reg[1]) begin
        ser_rx_dat <= ulpi_data_in[1];
        ser_rx_se0 <= ulpi_data_in[2];
      end
      if (state_reg == ulsm_pkg::ST_UART) begin
        uart_rxd <= ulpi_data_in[1];
      end
    end
  end

  // Drive is withdrawn at once if the transceiver takes the bus during a write
  assign ulpi_data_oe = (in_mode || !ulpi_dir) ? oe_reg : 8'h00;
  assign ulpi_data_out = dout_reg;
  assign ulpi_stp = stp_reg;
  assign phy_cs = cs_reg;
  assign int_seen = int_reg;
  assign mode_serial = (state_reg == ulsm_pkg::ST_SER);
  assign mode_uart = (state_reg == ulsm_pkg::ST_UART);
  assign busy = !(state_reg == ulsm_pkg::ST_IDLE) && !in_mode;

  // Cycles chip select has been low, saturating; watched by the checks below
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs_low_cnt_reg <= 16'h0000;
    end else if (phy_cs) begin
      cs_low_cnt_reg <= 16'h0000;
    end else if (cs_low_cnt_reg != 16'hFFFF) begin
      cs_low_cnt_reg <= cs_low_cnt_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_write_ends_stp: assert property ((state_reg == ulsm_pkg::ST_DATA && ulpi_nxt && !ulpi_dir)
    |=> ulpi_stp && ulpi_data_out == 8'h00) else $error("stop missing after write");
  a_exit_holds_stp: assert property ((state_reg == ulsm_pkg::ST_EXIT && ulpi_dir)
    |=> ulpi_stp) else $error("stop dropped before dir fell");
  a_txen_drive: assert property (mode_serial |-> ulpi_data_oe[0])
    else $error("transmit enable not driven");
  a_ser_bidir: assert property (mode_serial |-> (ulpi_data_oe[1] == ulpi_data_out[0])
    && (ulpi_data_oe[2] == ulpi_data_out[0])) else $error("serial bit direction wrong");
  a_reserved_free: assert property (in_mode |-> ulpi_data_oe[7:2] == 6'h00 || mode_serial
    && ulpi_data_oe[7:3] == 5'h00) else $error("reserved bits driven");
  a_uart_precharge: assert property ((state_reg == ulsm_pkg::ST_WAITDIR && ulpi_dir
    && uart_sel_reg) |=> (ulpi_data_oe == 8'h00) [*6] ##1 mode_uart)
    else $error("precharge window wrong");
  a_uart_map: assert property (mode_uart |-> ulpi_data_oe == 8'h01)
    else $error("uart drive map wrong");
  a_int_wakes: assert property ((in_mode && ulpi_data_in[3]) |=> state_reg == ulsm_pkg::ST_EXIT
    && int_seen) else $error("interrupt did not wake");
  a_cs_off_time: assert property (cs_low_cnt_reg <= CS_CYC)
    else $error("chip select never returned");
  a_cs_off_len: assert property ($rose(phy_cs) |-> cs_low_cnt_reg == CS_CYC)
    else $error("chip select off time wrong");

  c_serial_entry: cover property ($rose(mode_serial));
  c_uart_entry: cover property ($rose(mode_uart));
  c_cs_exit: cover property (mode_uart ##1 !phy_cs);
  c_int_exit: cover property (in_mode && ulpi_data_in[3]);

endmodule : ulsm_ctrl

// ### test/ulsm_phy_model.sv
// Behavioural transceiver on the far side of the ULPI pins: register writes, serial and UART modes.
// Assumes the bench resolves the data bus from both drive enables and feeds the level back here.
`timescale 1ns/1ps

module ulsm_phy_model #(
  parameter int HOLD_CYC = 5 // Chip-select off cycles that force a power-on reset
) (
  input wire logic clk, // ULPI clock
  input wire logic cs, // Chip select, active high
  input wire logic stp, // ULPI stop
  input wire logic [7:0] bus, // Resolved data bus level
  input wire logic int_evt, // Unmasked interrupt event
  input wire logic dp, // Plus line level
  input wire logic rx_dat, // Received differential data
  input wire logic rx_se0, // Received SE0
  output logic dir, // ULPI direction
  output logic nxt, // ULPI next
  output logic [7:0] p_out, // Data drive value
  output logic [7:0] p_oe, // Data drive enable
  output logic dm // Minus line level
);
  localparam logic [2:0] M_SYNC = 3'h0, M_TURN = 3'h1, M_PRE = 3'h2, M_SER = 3'h3;
  localparam logic [2:0] M_UART = 3'h4, M_EXIT = 3'h5;
  logic [2:0] md = 3'h0, cnt = 3'h0;
  logic [1:0] ph = 2'h0;
  logic [5:0] adr = 6'h00;
  logic [7:0] wd = 8'h00, cs_cnt = 8'h00;
  logic [7:0] func_reg = 8'h41, ifc_reg = 8'h00, otg_reg = 8'h06, car_reg = 8'h00;
  logic int_reg = 1'b0;

  // Mode sequencing and register file; a released chip select drops every mode
  always_ff @(posedge clk) begin
    if (int_evt) int_reg <= 1'b1;
    if (!cs) begin
      cs_cnt <= cs_cnt + 8'h01;
      md <= M_SYNC;
      ph <= 2'h0;
      ifc_reg[2:1] <= 2'h0;
      car_reg[3:2] <= 2'h0;
    end else begin
      cs_cnt <= 8'h00;
      if (cs_cnt >= HOLD_CYC) begin
        func_reg <= 8'h41;
        ifc_reg <= 8'h00;
        otg_reg <= 8'h06;
        car_reg <= 8'h00;
        int_reg <= 1'b0;
      end
      case (md)
        M_SYNC: begin
          if (ph == 2'h0 && nxt) begin
            adr <= bus[5:0];
            ph <= 2'h1;
          end else if (ph == 2'h1 && nxt) begin
            wd <= bus;
            ph <= 2'h2;
          end else if (ph == 2'h2 && stp) begin
            ph <= 2'h0;
            case (adr)
              6'h05: func_reg <= func_reg | wd;
              6'h06: func_reg <= func_reg & ~wd;
              6'h08: ifc_reg <= ifc_reg | wd;
              6'h0C: otg_reg <= otg_reg & ~wd;
              6'h1A: car_reg <= car_reg | wd;
              default: ;
            endcase
          end else if (ph == 2'h0 && (ifc_reg[1] || (ifc_reg[2] && car_reg[3:2] == 2'h3))) begin
            md <= M_TURN;
          end
        end
        M_TURN: begin
          md <= ifc_reg[1] ? M_SER : M_PRE;
          cnt <= 3'h0;
        end
        M_PRE: begin
          cnt <= cnt + 3'h1;
          if (cnt == 3'h4) md <= M_UART;
        end
        M_SER, M_UART: begin
          if (stp) md <= M_EXIT;
          cnt <= 3'h0;
        end
        default: begin
          // Bus held low two cycles before direction drops
          cnt <= cnt + 3'h1;
          if (cnt == 3'h1) begin
            md <= M_SYNC;
            ifc_reg[2:1] <= 2'h0;
            car_reg[3:2] <= 2'h0;
            int_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // Pin drive per mode; next is only meaningful in synchronous mode
  assign dir = cs && md != M_SYNC;
  assign nxt = cs && md == M_SYNC && !stp && ((ph == 2'h0 && bus[7:6] == 2'h2) || ph == 2'h1);
  assign dm = (md == M_UART) ? bus[0] : 1'b0;
  always_comb begin
    p_oe = 8'h00;
    p_out = 8'h00;
    case (md)
      M_PRE: begin p_oe = 8'hFF; p_out = 8'h01; end
      M_SER: begin p_oe = bus[0] ? 8'hF8 : 8'hFE; p_out = {4'h0, int_reg, rx_se0, rx_dat, 1'b0}; end
      M_UART: begin p_oe = 8'hFE; p_out = {4'h0, int_reg, 1'b0, dp, 1'b0}; end
      M_EXIT: p_oe = 8'hFF;
      default: ;
    endcase
    if (!cs) p_oe = 8'h00;
  end
endmodule : ulsm_phy_model

// ### test/tb.sv
// Self-checking bench: controller against the transceiver model, serial and UART round trips.
// Assumes a free-running 50 MHz clock; mode changes are checked against a queue of expectations.
`timescale 1ns/1ps

module tb;
  logic clk = 1'b0, flt = 1'b0;
  logic rstn, cmd_valid, keep_clock, uart_low_speed, ser_tx_en, ser_tx_dat, ser_tx_se0;
  logic uart_txd, int_evt, dp, rx_dat, rx_se0;
  ulsm_pkg::ulsm_cmd_e cmd;
  logic cmd_ready, ser_rx_dat, ser_rx_se0, uart_rxd, mode_serial, mode_uart, int_seen, busy;
  logic dir, nxt, stp, cs, dm;
  logic [7:0] d_out, d_oe, p_out, p_oe, bus;
  logic [1:0] exp_q[$];
  logic [1:0] mode_prev = 2'h0;
  int err_total = 0;
  int tests_run = 0;

  // Undriven bus bits show a pattern that flips every cycle, never a stale level
  always #10 clk = ~clk;
  always @(posedge clk) flt <= ~flt;
  assign bus = (d_oe & d_out) | (~d_oe & p_oe & p_out) | (~d_oe & ~p_oe & {8{flt}});

  ulsm_ctrl #(.POWERDOWN_HOLD_NS(100)) ulsm_ctrl_i (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .keep_clock(keep_clock), .uart_low_speed(uart_low_speed),
    .ser_tx_en(ser_tx_en), .ser_tx_dat(ser_tx_dat), .ser_tx_se0(ser_tx_se0),
    .ser_rx_dat(ser_rx_dat), .ser_rx_se0(ser_rx_se0), .uart_txd(uart_txd), .uart_rxd(uart_rxd),
    .mode_serial(mode_serial), .mode_uart(mode_uart), .int_seen(int_seen), .busy(busy),
    .ulpi_dir(dir), .ulpi_nxt(nxt), .ulpi_stp(stp), .ulpi_data_in(bus), .ulpi_data_out(d_out),
    .ulpi_data_oe(d_oe), .phy_cs(cs));
  ulsm_phy_model #(.HOLD_CYC(5)) ulsm_phy_model_i (.clk(clk), .cs(cs), .stp(stp), .bus(bus),
    .int_evt(int_evt), .dp(dp), .rx_dat(rx_dat), .rx_se0(rx_se0), .dir(dir), .nxt(nxt),
    .p_out(p_out), .p_oe(p_oe), .dm(dm));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict();
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Issue one order, note the mode it should lead to, wait until the sequence settles
  task automatic order(input ulsm_pkg::ulsm_cmd_e c, input logic [1:0] m);
    exp_q.push_back(m);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    repeat (50) begin
      @(negedge clk);
      if (cmd_ready === 1'b1) break;
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (300) begin
      @(negedge clk);
      if (busy === 1'b0 && {mode_serial, mode_uart} === m) break;
    end
  endtask : order

  // Watcher: each mode change takes the oldest note; direction must stand in any mode
  always @(negedge clk) begin
    if (rstn === 1'b1 && {mode_serial, mode_uart} !== mode_prev) begin
      check({mode_serial, mode_uart}, exp_q.size() > 0 ? exp_q.pop_front() : 2'h3);
      mode_prev = {mode_serial, mode_uart};
    end
    if (mode_serial === 1'b1 || mode_uart === 1'b1) check(dir, 1'b1);
  end

  initial begin
    #(20 * 20000);
    err_total++;
    give_verdict();
  end

  initial begin
    {rstn, cmd_valid, ser_tx_en, ser_tx_dat, ser_tx_se0, uart_txd, int_evt, rx_dat, rx_se0} = 9'h000;
    {keep_clock, uart_low_speed, dp} = 3'h7;
    cmd = ulsm_pkg::CMD_ENTER_SERIAL;
    void'($urandom(44144));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    order(ulsm_pkg::CMD_ENTER_SERIAL, 2'h2);
    check(ulsm_phy_model_i.ifc_reg[3:1], 3'h5);
    // Transmit then receive, one cycle of lag each way
    repeat (8) begin
      @(posedge clk);
      {ser_tx_en, ser_tx_dat, ser_tx_se0} <= {1'b1, 2'($urandom)};
      @(posedge clk);
      @(negedge clk);
      check(bus[2:0], {ser_tx_se0, ser_tx_dat, 1'b1});
      check(bus[7:3], 5'h00);
    end
    repeat (8) begin
      @(posedge clk);
      {ser_tx_en, rx_dat, rx_se0} <= {1'b0, 2'($urandom)};
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({ser_rx_se0, ser_rx_dat}, {rx_se0, rx_dat});
    end
    // Interrupt in serial mode wakes the bus back to synchronous
    exp_q.push_back(2'h0);
    @(posedge clk);
    int_evt <= 1'b1;
    @(posedge clk);
    int_evt <= 1'b0;
    repeat (60) @(posedge clk);
    check({int_seen, dir, busy}, 3'h4);
    for (int ls = 0; ls < 2; ls++) begin
      @(posedge clk);
      uart_low_speed <= ls[0];
      order(ulsm_pkg::CMD_ENTER_UART, 2'h1);
      check(ulsm_phy_model_i.func_reg[2:0], ls ? 3'h2 : 3'h1);
      check({ulsm_phy_model_i.otg_reg[2:1], ulsm_phy_model_i.car_reg[3:2]}, 4'h3);
      check({ulsm_phy_model_i.ifc_reg[3], int_seen}, 2'h2);
      repeat (6) begin
        @(posedge clk);
        {uart_txd, dp} <= 2'($urandom);
        @(posedge clk);
        @(negedge clk);
        check({dm, uart_rxd}, {uart_txd, dp});
        check(bus[7:2], 6'h00);
      end
      order(ls ? ulsm_pkg::CMD_EXIT_CS : ulsm_pkg::CMD_EXIT_STOP, 2'h0);
      check({dir, busy}, 2'h0);
    end
    check(ulsm_phy_model_i.func_reg, 8'h41);
    give_verdict();
  end
endmodule : tb
